// file: rtl/fws_ctrl.sv
`timescale 1ns/1ps
`include "fws_defines.svh"
// How it works
// - After bit 6 stops toggling, the host reads once more for valid data.
// - Host may use output enable or chip select as read strobe.
// - After failure the host must write Reset to regain array read.
// - Host checks bit 3 before and after each added sector.
module fws_ctrl #(
    parameter int AddrWidth = 20,
    parameter int PowerUpCycles = `FWS_T_PWRUP_CYC,
    parameter int PollLimit = `FWS_POLL_LIMIT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // User orders
    input wire logic opValid,
    output logic opReady,
    input wire fws_pkg::fws_op_t opCode,
    input wire logic [AddrWidth-1:0] opAddr,
    input wire logic [7:0] opData,
    input wire logic useCeStrobe,
    // User results
    output logic doneValid,
    output fws_pkg::fws_status_t doneStatus,
    output logic [7:0] doneData,
    output logic flashBusy,
    // Flash pins
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN,
    output logic [AddrWidth-1:0] flashAddr,
    output logic [7:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [7:0] flashDqIn,
    input wire logic readyBusyNOut,
    input wire logic lowSupply
);
    import fws_pkg::*;

    fws_state_t state_r;
    fws_op_t op_r;
    fws_status_t failStatus_r;
    logic [AddrWidth-1:0] addr_r;
    logic [7:0] data_r;
    logic [7:0] firstRd_r;
    logic [2:0] seqIdx_r;
    logic [31:0] pollCnt_r;
    logic [31:0] puCnt_r;
    logic puDone_r;
    logic recheck_r;
    logic req_r;
    logic useCe_r;
    logic rbSync1_r, rbSync2_r;
    logic lowSync1_r, lowSync2_r;
    logic [AddrWidth+7:0] word;
    logic toggled;

    fws_cyc_if #(.AddrWidth(AddrWidth)) cycBus ();

    // ==========================================================
    // Command cycle tables
    function automatic logic [2:0] seqLen(input fws_op_t op);
        unique case (op)
            OP_PROGRAM: seqLen = 3'd4;
            OP_SECTOR_ERASE, OP_CHIP_ERASE: seqLen = 3'd6;
            default: seqLen = 3'd1;
        endcase
    endfunction

    function automatic logic [AddrWidth+7:0] cmdWord(
        input fws_op_t op, input logic [2:0] i,
        input logic [AddrWidth-1:0] a, input logic [7:0] d);
        logic [AddrWidth-1:0] u1;
        logic [AddrWidth-1:0] u2;
        u1 = AddrWidth'(`FWS_UNLOCK_ADDR1);
        u2 = AddrWidth'(`FWS_UNLOCK_ADDR2);
        if (i == seqLen(op) - 3'd1) begin
            unique case (op)
                OP_PROGRAM: cmdWord = {a, d};
                OP_CHIP_ERASE: cmdWord = {u1, `FWS_CMD_CHIP};
                OP_SUSPEND: cmdWord = {a, `FWS_CMD_SUSPEND};
                OP_RESUME: cmdWord = {a, `FWS_CMD_RESUME};
                OP_RESET: cmdWord = {a, `FWS_CMD_RESET};
                default: cmdWord = {a, `FWS_CMD_SECTOR};
            endcase
        end else if (i == 3'd0 || i == 3'd3) begin
            cmdWord = {u1, `FWS_CMD_UNLOCK1};
        end else if (i == 3'd1 || i == 3'd4) begin
            cmdWord = {u2, `FWS_CMD_UNLOCK2};
        end else begin
            cmdWord = {u1, (op == OP_PROGRAM) ? `FWS_CMD_PROGRAM
                                              : `FWS_CMD_ERASE};
        end
    endfunction

    always_comb begin
        if (state_r == S_RESET) begin
            word = {addr_r, `FWS_CMD_RESET};
        end else begin
            word = cmdWord(op_r, seqIdx_r, addr_r, data_r);
        end
    end

    assign toggled = cycBus.rdata[`FWS_DQ_TOGGLE1] ^
                     firstRd_r[`FWS_DQ_TOGGLE1];
    assign cycBus.req = req_r;
    assign cycBus.wr = (state_r == S_WRITE) || (state_r == S_RESET);
    assign cycBus.useCe = useCe_r;
    assign cycBus.addr = cycBus.wr ? word[AddrWidth+7:8] : addr_r;
    assign cycBus.wdata = word[7:0];

    fws_bus_cycle #(.AddrWidth(AddrWidth)) u_bus (
        .clock(clock),
        .rstn(rstn),
        .cyc(cycBus.cyc),
        .flashCeN(flashCeN),
        .flashOeN(flashOeN),
        .flashWeN(flashWeN),
        .flashAddr(flashAddr),
        .flashDqOut(flashDqOut),
        .flashDqOe(flashDqOe),
        .flashDqIn(flashDqIn)
    );

    // ==========================================================
    // Pin synchronisers and busy flag
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rbSync1_r <= 1'b1;
            rbSync2_r <= 1'b1;
            lowSync1_r <= 1'b0;
            lowSync2_r <= 1'b0;
            flashBusy <= 1'b0;
        end else begin
            rbSync1_r <= readyBusyNOut;
            rbSync2_r <= rbSync1_r;
            lowSync1_r <= lowSupply;
            lowSync2_r <= lowSync1_r;
            flashBusy <= !rbSync2_r;
        end
    end

    // ==========================================================
    // Power-up hold-off: no command while the device starts
    always_ff @(posedge clock) begin
        if (!rstn) begin
            puCnt_r <= 32'h0;
            puDone_r <= 1'b0;
        end else if (puCnt_r == 32'(PowerUpCycles)) begin
            puDone_r <= 1'b1;
        end else begin
            puCnt_r <= puCnt_r + 32'h1;
        end
    end

    // ==========================================================
    // Operation sequencer
    task automatic finish(input fws_status_t st);
        doneValid <= 1'b1;
        doneStatus <= st;
        req_r <= 1'b0;
        state_r <= S_IDLE;
    endtask

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_r <= S_IDLE;
            op_r <= OP_READ;
            failStatus_r <= ST_OK;
            addr_r <= '0;
            data_r <= 8'h00;
            firstRd_r <= 8'h00;
            seqIdx_r <= 3'd0;
            pollCnt_r <= 32'h0;
            recheck_r <= 1'b0;
            req_r <= 1'b0;
            useCe_r <= 1'b0;
            opReady <= 1'b0;
            doneValid <= 1'b0;
            doneStatus <= ST_OK;
            doneData <= 8'h00;
        end else begin
            doneValid <= 1'b0;
            unique case (state_r)
                S_IDLE: begin
                    opReady <= puDone_r && !(opValid && opReady);
                    if (opValid && opReady) begin
                        op_r <= opCode;
                        addr_r <= opAddr;
                        data_r <= opData;
                        useCe_r <= useCeStrobe;
                        seqIdx_r <= 3'd0;
                        pollCnt_r <= 32'h0;
                        recheck_r <= 1'b0;
                        if (lowSync2_r) begin
                            finish(ST_LOCKOUT);
                        end else begin
                            req_r <= 1'b1;
                            unique case (opCode)
                                OP_READ: state_r <= S_FINAL;
                                OP_WAIT: state_r <= S_POLLA;
                                OP_ADD_SECTOR: state_r <= S_PRE3;
                                default: state_r <= S_WRITE;
                            endcase
                        end
                    end
                end
                S_WRITE: if (cycBus.ack) begin
                    if (seqIdx_r != seqLen(op_r) - 3'd1) begin
                        seqIdx_r <= seqIdx_r + 3'd1;
                    end else if (op_r == OP_ADD_SECTOR) begin
                        state_r <= S_POST3;
                    end else if (op_r == OP_RESUME || op_r == OP_RESET) begin
                        finish(ST_OK);
                    end else begin
                        // Status is valid right after the last write
                        state_r <= S_POLLA;
                    end
                end
                S_PRE3: if (cycBus.ack) begin
                    if (cycBus.rdata[`FWS_DQ_TIMER]) begin
                        finish(ST_REJECT);
                    end else begin
                        state_r <= S_WRITE;
                    end
                end
                S_POST3: if (cycBus.ack) begin
                    // High here: the added sector may have been refused
                    finish(cycBus.rdata[`FWS_DQ_TIMER] ? ST_REJECT
                                                       : ST_OK);
                end
                S_POLLA: if (cycBus.ack) begin
                    firstRd_r <= cycBus.rdata;
                    state_r <= S_POLLB;
                end
                S_POLLB: if (cycBus.ack) begin
                    if (op_r == OP_SECTOR_ERASE) begin
                        // Toggling proves the sequence was taken
                        finish(toggled ? ST_OK : ST_REJECT);
                    end else if (!toggled) begin
                        state_r <= S_FINAL;
                    end else if (cycBus.rdata[`FWS_DQ_FAIL]) begin
                        // Bit 5 counts only while toggling persists
                        if (recheck_r) begin
                            failStatus_r <= ST_FAIL;
                            state_r <= S_RESET;
                        end else begin
                            recheck_r <= 1'b1;
                            state_r <= S_POLLA;
                        end
                    end else if (pollCnt_r == 32'(PollLimit)) begin
                        failStatus_r <= ST_TIMEOUT;
                        state_r <= S_RESET;
                    end else begin
                        pollCnt_r <= pollCnt_r + 32'h1;
                        state_r <= S_POLLA;
                    end
                end
                S_FINAL: if (cycBus.ack) begin
                    // Bit 7 may settle ahead of the rest of the byte
                    doneData <= cycBus.rdata;
                    finish((op_r == OP_PROGRAM && cycBus.rdata != data_r)
                           ? ST_FAIL : ST_OK);
                end
                S_RESET: if (cycBus.ack) begin
                    finish(failStatus_r);
                end
            endcase
        end
    end
endmodule

// file: common/fws_defines.svh
`ifndef FWS_DEFINES_SVH
`define FWS_DEFINES_SVH

// ==========================================================
// Clock and timing
`define FWS_CLK_NS 10
`define FWS_CYC_UP(ns) (((ns) + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_T_ACC_NS 70
`define FWS_T_WP_NS 35
`define FWS_T_WPH_NS 30
`define FWS_T_PWRUP_NS 50000
`define FWS_T_ACC_CYC `FWS_CYC_UP(`FWS_T_ACC_NS)
`define FWS_T_WP_CYC `FWS_CYC_UP(`FWS_T_WP_NS)
`define FWS_T_WPH_CYC `FWS_CYC_UP(`FWS_T_WPH_NS)
`define FWS_T_PWRUP_CYC `FWS_CYC_UP(`FWS_T_PWRUP_NS)
`define FWS_SYNC_CYC 2
`define FWS_POLL_LIMIT 50000000

// ==========================================================
// Command cycles
`define FWS_UNLOCK_ADDR1 32'h0000_0555
`define FWS_UNLOCK_ADDR2 32'h0000_02AA
`define FWS_CMD_UNLOCK1 8'hAA
`define FWS_CMD_UNLOCK2 8'h55
`define FWS_CMD_PROGRAM 8'hA0
`define FWS_CMD_ERASE 8'h80
`define FWS_CMD_SECTOR 8'h30
`define FWS_CMD_CHIP 8'h10
`define FWS_CMD_SUSPEND 8'hB0
`define FWS_CMD_RESUME 8'h30
`define FWS_CMD_RESET 8'hF0

// ==========================================================
// Status bit positions
`define FWS_DQ_POLL 7
`define FWS_DQ_TOGGLE1 6
`define FWS_DQ_FAIL 5
`define FWS_DQ_TIMER 3
`define FWS_DQ_TOGGLE2 2

`endif

// file: common/fws_pkg.sv
package fws_pkg;

    typedef enum logic [3:0] {
        OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_ADD_SECTOR,
        OP_CHIP_ERASE, OP_WAIT, OP_SUSPEND, OP_RESUME, OP_RESET
    } fws_op_t;

    typedef enum logic [2:0] {
        ST_OK, ST_FAIL, ST_TIMEOUT, ST_REJECT, ST_LOCKOUT
    } fws_status_t;

    typedef enum {
        S_IDLE, S_WRITE, S_PRE3, S_POST3, S_POLLA, S_POLLB,
        S_FINAL, S_RESET
    } fws_state_t;

    typedef enum {
        B_IDLE, B_SETUP, B_STROBE, B_SAMPLE, B_RECOVER
    } fws_bus_state_t;

endpackage

// file: common/fws_cyc_if.sv
`timescale 1ns/1ps
interface fws_cyc_if #(parameter int AddrWidth = 20);
    logic req;
    logic wr;
    logic useCe;
    logic [AddrWidth-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    modport master (output req, wr, useCe, addr, wdata, input ack, rdata);
    modport cyc (input req, wr, useCe, addr, wdata, output ack, rdata);
endinterface

// file: rtl/fws_bus_cycle.sv
`timescale 1ns/1ps
`include "fws_defines.svh"
module fws_bus_cycle #(
    parameter int AddrWidth = 20
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Cycle requests
    fws_cyc_if.cyc cyc,
    // Flash pins
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN,
    output logic [AddrWidth-1:0] flashAddr,
    output logic [7:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [7:0] flashDqIn
);
    import fws_pkg::*;

    localparam logic [3:0] AccCyc = 4'(`FWS_T_ACC_CYC);
    localparam logic [3:0] WpCyc = 4'(`FWS_T_WP_CYC);
    localparam logic [3:0] WphCyc = 4'(`FWS_T_WPH_CYC);
    localparam logic [3:0] SyncCyc = 4'(`FWS_SYNC_CYC);

    fws_bus_state_t state_r;
    logic [3:0] cnt_r;
    logic wr_r;
    logic useCe_r;
    logic [7:0] dqSync1_r;
    logic [7:0] dqSync2_r;

    // ==========================================================
    // Data pin synchroniser
    always_ff @(posedge clock) begin
        dqSync1_r <= flashDqIn;
        dqSync2_r <= dqSync1_r;
    end

    // ==========================================================
    // One asynchronous read or write cycle per request
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_r <= B_IDLE;
            cnt_r <= 4'h0;
            wr_r <= 1'b0;
            useCe_r <= 1'b0;
            flashCeN <= 1'b1;
            flashOeN <= 1'b1;
            flashWeN <= 1'b1;
            flashAddr <= '0;
            flashDqOut <= 8'h00;
            flashDqOe <= 1'b0;
            cyc.ack <= 1'b0;
            cyc.rdata <= 8'h00;
        end else begin
            cyc.ack <= 1'b0;
            unique case (state_r)
                B_IDLE: begin
                    // Ack still high means the request is the old one
                    if (cyc.req && !cyc.ack) begin
                        wr_r <= cyc.wr;
                        useCe_r <= cyc.useCe;
                        flashAddr <= cyc.addr;
                        flashDqOut <= cyc.wdata;
                        flashDqOe <= cyc.wr;
                        flashOeN <= 1'b1;
                        // Non-controlling strobe goes first
                        if (cyc.wr || !cyc.useCe) begin
                            flashCeN <= 1'b0;
                        end else begin
                            flashOeN <= 1'b0;
                        end
                        state_r <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    if (wr_r) begin
                        flashWeN <= 1'b0;
                        cnt_r <= WpCyc - 4'h1;
                    end else begin
                        if (useCe_r) begin
                            flashCeN <= 1'b0;
                        end else begin
                            flashOeN <= 1'b0;
                        end
                        cnt_r <= AccCyc - 4'h1;
                    end
                    state_r <= B_STROBE;
                end
                B_STROBE: begin
                    if (cnt_r != 4'h0) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else if (wr_r) begin
                        flashWeN <= 1'b1;
                        cnt_r <= WphCyc - 4'h1;
                        state_r <= B_RECOVER;
                    end else begin
                        cnt_r <= SyncCyc - 4'h1;
                        state_r <= B_SAMPLE;
                    end
                end
                B_SAMPLE: begin
                    if (cnt_r != 4'h0) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else begin
                        // Closing the strobe ends the read for toggling
                        cyc.rdata <= dqSync2_r;
                        flashCeN <= 1'b1;
                        flashOeN <= 1'b1;
                        cnt_r <= WphCyc - 4'h1;
                        state_r <= B_RECOVER;
                    end
                end
                B_RECOVER: begin
                    flashCeN <= 1'b1;
                    flashDqOe <= 1'b0;
                    if (cnt_r != 4'h0) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else begin
                        cyc.ack <= 1'b1;
                        state_r <= B_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// file: sim/fws_ctrl_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Pin and handshake checks on the controller's ports
module fws_ctrl_checker #(
    parameter int AddrWidth = 20
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // User side
    input wire logic opValid,
    input wire logic opReady,
    input wire logic lowSupply,
    input wire logic doneValid,
    input wire fws_pkg::fws_status_t doneStatus,
    input wire logic flashBusy,
    // Flash pins
    input wire logic flashCeN,
    input wire logic flashOeN,
    input wire logic flashWeN,
    input wire logic flashDqOe,
    input wire logic readyBusyNOut
);
    import fws_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    power_up_wait_a: assert property (
        $rose(rstn) |-> !opReady [*8])
        else $error("order taken too soon after reset");
    reset_idle_a: assert property (
        $rose(rstn) |-> flashCeN && flashOeN && flashWeN && !flashDqOe)
        else $error("flash pins not idle after reset");
    write_gate_a: assert property (
        !flashWeN |-> !flashCeN && flashOeN && flashDqOe)
        else $error("write strobe without select or with output enable");
    we_pulse_a: assert property (
        $fell(flashWeN) |-> !flashWeN [*4] ##1 flashWeN)
        else $error("write pulse length wrong");
    no_contend_a: assert property (
        !flashOeN |-> !flashDqOe)
        else $error("data pins driven during a read");
    lockout_refuse_a: assert property (
        opValid && opReady && $past(lowSupply, 2) |=> doneValid &&
        doneStatus == ST_LOCKOUT && flashCeN && flashWeN)
        else $error("order not refused under low supply");
    busy_seen_a: assert property (
        !readyBusyNOut [*5] |-> flashBusy)
        else $error("busy pin not reflected");
    ready_seen_a: assert property (
        readyBusyNOut [*5] |-> !flashBusy)
        else $error("ready pin not reflected");
    done_pulse_a: assert property (
        doneValid |=> !doneValid && opReady)
        else $error("done not a single pulse followed by ready");

    cover property (doneValid && doneStatus == ST_FAIL);
    cover property (doneValid && doneStatus == ST_LOCKOUT);
    cover property ($fell(flashWeN));
endmodule

bind fws_ctrl fws_ctrl_checker #(.AddrWidth(AddrWidth)) fws_ctrl_checker_inst (
    .clock(clock), .rstn(rstn), .opValid(opValid), .opReady(opReady),
    .lowSupply(lowSupply), .doneValid(doneValid), .doneStatus(doneStatus),
    .flashBusy(flashBusy), .flashCeN(flashCeN), .flashOeN(flashOeN),
    .flashWeN(flashWeN), .flashDqOe(flashDqOe),
    .readyBusyNOut(readyBusyNOut));

// file: sim/fws_flash_model.sv
`timescale 1ns/1ps
`include "fws_defines.svh"
// ==========================================================
// Flash device model, stepped on the falling edge so that the
// controller's rising-edge pins are settled whenever they are seen
module fws_flash_model #(
    parameter int ProgCycles = 40,
    parameter int ProtCycles = 20,
    parameter int WindowCycles = 200,
    parameter int EraseCycles = 100,
    parameter int ProtSector = 15
) (
    // Clock, reset and supply
    input wire logic clock,
    input wire logic rstn,
    input wire logic lowSupply,
    // Bus pins
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [19:0] addr,
    input wire logic [7:0] dqIn,
    output logic [7:0] dqOut,
    output logic readyBusyNOut
);
    logic [7:0] mem [256];
    logic [15:0] eraseSet;
    logic [19:0] pAddr;
    logic [7:0] pData;
    logic prog, fail, t6, t2, weLast, rdLast, u1, u2, susp;
    int stage, busyCnt, winCnt;

    initial begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'hA5;
        dqOut = 8'h00;
    end

    // Pulled up, so released reads high
    assign readyBusyNOut = !((busyCnt > 0 && !susp) || winCnt > 0 ||
                             fail);

    function automatic logic [7:0] rdVal(input logic [19:0] a);
        if (prog)
            return {~pData[7], t6, fail, 5'h00};
        if (susp)
            return eraseSet[a[7:4]] ? {5'h10, t2, 2'b0} : mem[a[7:0]];
        if (busyCnt > 0 || winCnt > 0)
            return {1'b0, t6, 2'b0, winCnt == 0, eraseSet[a[7:4]] & t2, 2'b0};
        return mem[a[7:0]];
    endfunction

    task automatic cmdWrite(input logic [19:0] a, input logic [7:0] d);
        u1 = 32'(a) == `FWS_UNLOCK_ADDR1 && d == `FWS_CMD_UNLOCK1;
        u2 = 32'(a) == `FWS_UNLOCK_ADDR2 && d == `FWS_CMD_UNLOCK2;
        if (d == `FWS_CMD_RESET) begin
            stage = 0;
            fail = 1'b0;
            prog = 1'b0;
            susp = 1'b0;
        end else if (busyCnt > 0 && !prog && d == `FWS_CMD_SUSPEND)
            susp = 1'b1;
        else if (susp && d == `FWS_CMD_RESUME)
            susp = 1'b0;
        else if (winCnt > 0 && d == `FWS_CMD_SECTOR)
            eraseSet[a[7:4]] = 1'b1;
        else if (busyCnt > 0 || winCnt > 0 || fail)
            stage = 0;
        else if (stage == 0 || stage == 4)
            stage = u1 ? stage + 1 : 0;
        else if (stage == 1 || stage == 5)
            stage = u2 ? stage + 1 : 0;
        else if (stage == 2)
            stage = d == `FWS_CMD_PROGRAM ? 3 : (d == `FWS_CMD_ERASE ? 4 : 0);
        else begin
            if (stage == 3) begin
                pAddr = a;
                pData = d;
                prog = 1'b1;
                if (a[7:4] == 4'(ProtSector))
                    busyCnt = ProtCycles;
                else if ((d & ~mem[a[7:0]]) != 8'h00)
                    fail = 1'b1;
                else
                    busyCnt = ProgCycles;
            end else if (d == `FWS_CMD_SECTOR) begin
                eraseSet[a[7:4]] = 1'b1;
                winCnt = WindowCycles;
            end else if (d == `FWS_CMD_CHIP) begin
                eraseSet = '1;
                busyCnt = EraseCycles;
            end
            stage = 0;
        end
    endtask

    task automatic finishOp();
        if (prog && pAddr[7:4] != 4'(ProtSector))
            mem[pAddr[7:0]] = pData;
        for (int i = 0; i < 256; i++)
            if (!prog && eraseSet[i / 16] && i / 16 != ProtSector)
                mem[i] = 8'hFF;
        prog = 1'b0;
        eraseSet = '0;
    endtask

    always @(negedge clock) begin
        if (!rstn || lowSupply) begin
            stage = 0;
            busyCnt = 0;
            winCnt = 0;
            fail = 1'b0;
            prog = 1'b0;
            eraseSet = '0;
            t6 = 1'b0;
            t2 = 1'b0;
            susp = 1'b0;
        end else begin
            if (!weLast && weN && !ceN && oeN)
                cmdWrite(addr, dqIn);
            if (rdLast && (ceN || oeN)) begin
                t6 = !t6;
                t2 = !t2;
            end
            if (winCnt == 1)
                busyCnt = EraseCycles + 1;
            if (winCnt > 0)
                winCnt--;
            if (busyCnt == 1 && !susp)
                finishOp();
            if (busyCnt > 0 && !susp)
                busyCnt--;
        end
        weLast = weN;
        rdLast = !ceN && !oeN;
        // Released pins keep changing so a stale byte never passes
        dqOut = rdLast ? rdVal(addr) : ~dqOut;
    end
endmodule

// file: sim/fws_ctrl_test.sv
`timescale 1ns/1ps
module fws_ctrl_test;
    import fws_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic opValid = 1'b0;
    logic useCeStrobe = 1'b0;
    logic lowSupply = 1'b0;
    fws_op_t opCode = OP_READ;
    logic [19:0] opAddr = 20'h00000;
    logic [7:0] opData = 8'h00;
    logic opReady, doneValid, flashBusy, flashCeN, flashOeN, flashWeN;
    logic flashDqOe, readyBusyNOut;
    fws_status_t doneStatus;
    logic [7:0] doneData, flashDqOut, devDq, r;
    logic [19:0] flashAddr, a;
    wire logic [7:0] flashDqIn = flashDqOe ? flashDqOut : devDq;
    logic [7:0] mirror [256];
    int errors = 0;
    int checksDone = 0;
    int cycles = 0;
    int seed = 56;

    always #5 clock = ~clock;

    fws_ctrl #(.PowerUpCycles(10), .PollLimit(20)) fws_ctrl_inst (
        .clock(clock), .rstn(rstn), .opValid(opValid), .opReady(opReady),
        .opCode(opCode), .opAddr(opAddr), .opData(opData),
        .useCeStrobe(useCeStrobe), .doneValid(doneValid),
        .doneStatus(doneStatus), .doneData(doneData), .flashBusy(flashBusy),
        .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
        .flashAddr(flashAddr), .flashDqOut(flashDqOut),
        .flashDqOe(flashDqOe), .flashDqIn(flashDqIn),
        .readyBusyNOut(readyBusyNOut), .lowSupply(lowSupply));

    fws_flash_model fws_flash_model_inst (
        .clock(clock), .rstn(rstn), .lowSupply(lowSupply), .ceN(flashCeN),
        .oeN(flashOeN), .weN(flashWeN), .addr(flashAddr),
        .dqIn(flashDqOut), .dqOut(devDq), .readyBusyNOut(readyBusyNOut));

    task automatic summarize();
        if (errors == 0 && checksDone > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // One order through the user port; status compared with es, data with the mirror when chkData is set
    task automatic doOp(input fws_op_t c, input logic [19:0] ad,
            input logic ce, input logic [7:0] d, input fws_status_t es,
            input bit chkData);
        @(posedge clock);
        opValid <= 1'b1;
        opCode <= c;
        opAddr <= ad;
        opData <= d;
        useCeStrobe <= ce;
        @(posedge clock);
        while (opReady !== 1'b1)
            @(posedge clock);
        opValid <= 1'b0;
        @(posedge clock);
        while (doneValid !== 1'b1)
            @(posedge clock);
        check({5'h00, doneStatus}, {5'h00, es});
        if (chkData)
            check(doneData, mirror[ad[7:0]]);
    endtask

    task automatic programByte(input logic [19:0] ad, input logic [7:0] d,
            input logic ce);
        bit ok;
        if (ad[7:4] == 4'hF)
            ok = mirror[ad[7:0]] == d;
        else
            ok = (d & ~mirror[ad[7:0]]) == 8'h00;
        if (ok)
            mirror[ad[7:0]] = d;
        doOp(OP_PROGRAM, ad, ce, d, ok ? ST_OK : ST_FAIL, ok);
        doOp(OP_READ, ad, !ce, 8'h00, ST_OK, 1'b1);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        for (int i = 0; i < 256; i++)
            mirror[i] = 8'(i) ^ 8'hA5;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        lowSupply <= 1'b1;
        doOp(OP_READ, 20'h00023, 1'b0, 8'h00, ST_LOCKOUT, 1'b0);
        lowSupply <= 1'b0;
        repeat (3) @(posedge clock);
        doOp(OP_READ, 20'h00023, 1'b1, 8'h00, ST_OK, 1'b1);
        doOp(OP_SECTOR_ERASE, 20'h00010, 1'b0, 8'h00, ST_OK, 1'b0);
        doOp(OP_ADD_SECTOR, 20'h00020, 1'b0, 8'h00, ST_OK, 1'b0);
        for (int i = 16; i < 48; i++)
            mirror[i] = 8'hFF;
        doOp(OP_WAIT, 20'h00010, 1'b0, 8'h00, ST_OK, 1'b1);
        doOp(OP_READ, 20'h0002C, 1'b1, 8'h00, ST_OK, 1'b1);
        for (int k = 0; k < 6; k++) begin
            a = {12'h000, k[0] ? 4'h1 : 4'h2, 4'($random(seed))};
            r = 8'($random(seed));
            programByte(a, r, k[1]);
            programByte(a, ~r, k[2]);
        end
        programByte(20'h000F3, 8'h00, 1'b0);
        doOp(OP_SECTOR_ERASE, 20'h000F0, 1'b0, 8'h00, ST_OK, 1'b0);
        repeat (200) @(posedge clock);
        doOp(OP_SUSPEND, 20'h00033, 1'b0, 8'h00, ST_OK, 1'b1);
        doOp(OP_RESUME, 20'h00033, 1'b0, 8'h00, ST_OK, 1'b0);
        doOp(OP_WAIT, 20'h000F0, 1'b1, 8'h00, ST_OK, 1'b1);
        doOp(OP_RESET, 20'h00000, 1'b0, 8'h00, ST_OK, 1'b0);
        for (int i = 0; i < 240; i++)
            mirror[i] = 8'hFF;
        doOp(OP_CHIP_ERASE, 20'h00005, 1'b1, 8'h00, ST_OK, 1'b1);
        summarize();
    end
endmodule
